// ===== rtl/nic_regs.vh
`ifndef NIC_REGS_VH
`define NIC_REGS_VH
// APB register byte offsets
`define ADDR_CTRL        12'h000
`define ADDR_ENABLE      12'h004
`define ADDR_PRIO        12'h008
`define ADDR_PERIPH_CLR  12'h00C
`define ADDR_STATUS      12'h010
`define ADDR_VECTOR      12'h014
`define ADDR_EDGE_CLR    12'h018
`define ADDR_HALT_CAP    12'h01C
// Control register fields
`define CTRL_HALT_BIT    0
`define CTRL_WAIT_BIT    1
`define CTRL_TLI_RISE    2
`define CTRL_TRAP_BIT    3
`define CTRL_RETURN_FROM_IRQ_INSTR_BIT    4
`define CTRL_RIM_BIT     5
`define CTRL_SIM_BIT     6
// Condition code bit positions
`define CC_PRIO_HI       5
`define CC_PRIO_LO       3
// Priority pair encodings, {high,low}
`define LVL0             2'h2
`define LVL1             2'h1
`define LVL2             2'h0
`define LVL3             2'h3
// Vector numbering
`define NUM_MASKABLE     14
`define VEC_BASE         16'hFFE0
`define VEC_RESET        16'hFFFE
`define VEC_TRAP         16'hFFFC
`define VEC_TLI          16'hFFFA
`define PRIO_RESET_VAL   28'hFFFFFFF
`define HALT_CAP_RESET   14'h21BF
// Entry sequence: stack 5 bytes then 2-cycle vector fetch
`define STACK_CYCLES     3'h5
`define FETCH_CYCLES     3'h2
`endif

// ===== rtl/prio_rank.v
`timescale 1ns/1ps
`default_nettype none
`include "nic_regs.vh"
module prio_rank (
  input  wire [1:0] pair, // Encoded priority pair
  output wire [1:0] rank  // Numeric level 0..3
);
  assign rank = (pair == `LVL0) ? 2'h0 :
                (pair == `LVL1) ? 2'h1 :
                (pair == `LVL2) ? 2'h2 : 2'h3;
endmodule
`default_nettype wire

// ===== rtl/edge_sync.v
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter W = 14
) (
  input  wire         pclk,    // System clock
  input  wire         presetn, // Async reset, active low
  input  wire [W-1:0] din,     // Raw asynchronous inputs
  output wire [W-1:0] lvl,     // Synchronised level
  output wire [W-1:0] rise,    // Rising edge pulse
  output wire [W-1:0] fall     // Falling edge pulse
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign lvl  = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ===== rtl/nested_interrupt_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "nic_regs.vh"
module nested_interrupt_controller (
  input  wire        pclk,          // System clock
  input  wire        presetn,       // Async reset, active low
  input  wire        psel,          // APB select
  input  wire        penable,       // APB enable
  input  wire        pwrite,        // APB direction
  input  wire [11:0] paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  output reg  [31:0] prdata,        // APB read data
  output reg         pready,        // APB ready
  output reg         pslverr,       // APB error
  input  wire        tli_pin,       // Top-level interrupt pin
  input  wire [15:0] ext_pins,      // External pins, four per line
  input  wire [15:0] ext_pin_sel,   // Pin selects for OR grouping
  input  wire [9:0]  periph_flag,   // Peripheral status flags, vectors 4..13
  input  wire        cpu_instr_end, // Core at instruction boundary
  output reg  [7:0]  cc_out,        // Condition code interrupt bits
  output reg         cpu_stack,     // Core pushing context
  output reg         cpu_fetch,     // Core fetching vector
  output reg  [15:0] cpu_vector,    // Vector address
  output reg         cpu_halted,    // Core clock stopped
  output reg         cpu_waiting    // Core in wait mode
);
  localparam S_RUN   = 3'h0;
  localparam S_STACK = 3'h1;
  localparam S_FETCH = 3'h2;
  localparam S_HALT  = 3'h3;
  localparam S_WAIT  = 3'h4;
  localparam S_RESET = 3'h5;

  reg  [2:0]  state_q;
  reg  [2:0]  cnt_q;
  reg  [1:0]  pair_q;
  reg  [1:0]  saved_q [0:3];
  reg  [1:0]  depth_q;
  reg  [13:0] enable_q;
  reg  [27:0] prio_q;
  reg  [13:0] halt_cap_q;
  reg  [3:0]  edge_pend_q;
  reg  [13:0] periph_en_q;
  reg         tli_pend_q;
  reg         trap_pend_q;
  reg         tli_rise_q;
  reg         halt_exit_q;
  reg  [3:0]  win_q;
  reg         win_nmi_q;
  reg  [15:0] vec_q;
  reg  [1:0]  new_pair_q;

  wire [15:0] pin_lvl;
  wire [15:0] pin_rise;
  wire [15:0] pin_fall;
  wire [0:0]  tli_lvl;
  wire [0:0]  tli_r;
  wire [0:0]  tli_f;

  edge_sync #(.W(16)) u_pins (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (ext_pins),
    .lvl     (pin_lvl),
    .rise    (pin_rise),
    .fall    ()
  );
  edge_sync #(.W(1)) u_tli (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (tli_pin),
    .lvl     (tli_lvl),
    .rise    (tli_r),
    .fall    (tli_f)
  );

  wire [1:0] cur_rank;
  prio_rank u_cur (
    .pair (pair_q),
    .rank (cur_rank)
  );

  function [1:0] rank_of;
    input [1:0] p;
    begin
      case (p)
        `LVL0:   rank_of = 2'h0;
        `LVL1:   rank_of = 2'h1;
        `LVL2:   rank_of = 2'h2;
        default: rank_of = 2'h3;
      endcase
    end
  endfunction

  // Edge events per shared line, pins ORed within the group
  reg [3:0] line_edge;
  integer   li;
  always @* begin
    line_edge = 4'h0;
    for (li = 0; li < 4; li = li + 1)
      line_edge[li] = |(pin_rise[li*4 +: 4] & ext_pin_sel[li*4 +: 4]);
  end

  // Maskable request vector: bit 0 tied low (top-level taken separately), 1..4 ext lines, others peripherals
  // Vector 4 is shared by external line 3 and the first peripheral flag
  wire [13:0] req = {periph_flag[9:1] & periph_en_q[13:5],
                     edge_pend_q[3] | (periph_flag[0] & periph_en_q[4]),
                     edge_pend_q[2:0], 1'b0} & enable_q;

  // Arbitration
  reg [3:0] best_idx;
  reg [1:0] best_rank;
  reg       best_ok;
  reg [1:0] r;
  integer   vi;
  always @* begin
    best_idx  = 4'h0;
    best_rank = 2'h0;
    best_ok   = 1'b0;
    r         = 2'h0;
    for (vi = 13; vi >= 1; vi = vi - 1) begin
      r = rank_of(prio_q[vi*2 +: 2]);
      if (req[vi] && r > cur_rank && cur_rank != 2'h3 &&
          (!(halt_exit_q || state_q == S_HALT) || halt_cap_q[vi]) &&
          (!best_ok || r >= best_rank)) begin
        best_idx  = vi[3:0];
        best_rank = r;
        best_ok   = 1'b1;
      end
    end
  end

  wire take_tli  = tli_pend_q && enable_q[0];
  wire take_trap = trap_pend_q;
  wire any_req   = take_tli || take_trap || best_ok || (|req);

  wire apb_acc = psel && penable;
  wire wr      = apb_acc && pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= S_RESET;
      cnt_q       <= 3'h0;
      pair_q      <= `LVL3;
      depth_q     <= 2'h0;
      saved_q[0]  <= `LVL3;
      saved_q[1]  <= `LVL3;
      saved_q[2]  <= `LVL3;
      saved_q[3]  <= `LVL3;
      enable_q    <= 14'h0000;
      prio_q      <= `PRIO_RESET_VAL;
      halt_cap_q  <= `HALT_CAP_RESET;
      edge_pend_q <= 4'h0;
      periph_en_q <= 14'h0000;
      tli_pend_q  <= 1'b0;
      trap_pend_q <= 1'b0;
      tli_rise_q  <= 1'b1;
      halt_exit_q <= 1'b0;
      win_q       <= 4'h0;
      win_nmi_q   <= 1'b0;
      vec_q       <= `VEC_RESET;
      new_pair_q  <= `LVL3;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      cc_out      <= 8'h28;
      cpu_stack   <= 1'b0;
      cpu_fetch   <= 1'b0;
      cpu_vector  <= `VEC_RESET;
      cpu_halted  <= 1'b0;
      cpu_waiting <= 1'b0;
    end else begin
      pready  <= apb_acc && !pready;
      pslverr <= 1'b0;
      // Latch events; set wins over clear
      if (tli_rise_q ? tli_r[0] : tli_f[0])
        tli_pend_q <= 1'b1;
      else if (state_q == S_FETCH && win_nmi_q && vec_q == `VEC_TLI)
        tli_pend_q <= 1'b0;
      edge_pend_q <= (edge_pend_q & ~((state_q == S_FETCH && !win_nmi_q &&
                     win_q >= 4'h1 && win_q <= 4'h4) ? (4'h1 << (win_q - 4'h1)) : 4'h0))
                     | line_edge;
      if (apb_acc && !pready) begin
        if (pwrite) begin
          case (paddr)
            `ADDR_CTRL: begin
              tli_rise_q <= pwdata[`CTRL_TLI_RISE];
              if (pwdata[`CTRL_TRAP_BIT])
                trap_pend_q <= 1'b1;
              if (pwdata[`CTRL_RETURN_FROM_IRQ_INSTR_BIT] && state_q == S_RUN) begin
                pair_q  <= saved_q[depth_q - 2'h1];
                depth_q <= depth_q - 2'h1;
              end
              if (pwdata[`CTRL_RIM_BIT])
                pair_q <= `LVL0;
              if (pwdata[`CTRL_SIM_BIT])
                pair_q <= `LVL3;
              if (pwdata[`CTRL_HALT_BIT]) begin
                pair_q <= `LVL0;
                state_q <= S_HALT;
              end else if (pwdata[`CTRL_WAIT_BIT]) begin
                pair_q <= `LVL0;
                state_q <= S_WAIT;
              end
            end
            `ADDR_ENABLE:   enable_q <= pwdata[13:0];
            `ADDR_PRIO: begin : prio_wr
              integer k;
              for (k = 0; k < 14; k = k + 1)
                if (pwdata[k*2 +: 2] != `LVL0)
                  prio_q[k*2 +: 2] <= pwdata[k*2 +: 2];
            end
            `ADDR_PERIPH_CLR: periph_en_q <= pwdata[13:0];
            `ADDR_EDGE_CLR:   edge_pend_q <= edge_pend_q & ~pwdata[4:1] | line_edge;
            `ADDR_HALT_CAP:   halt_cap_q <= pwdata[13:0];
            default:          pslverr <= 1'b1;
          endcase
        end else begin
          case (paddr)
            `ADDR_CTRL:      prdata <= {25'h0, 4'h0, tli_rise_q, 2'h0};
            `ADDR_ENABLE:    prdata <= {18'h0, enable_q};
            `ADDR_PRIO:      prdata <= {4'h0, prio_q};
            `ADDR_PERIPH_CLR: prdata <= {18'h0, periph_en_q};
            `ADDR_STATUS:    prdata <= {16'h0, cc_out, 1'b0, state_q, edge_pend_q};
            `ADDR_VECTOR:    prdata <= {16'h0, vec_q};
            `ADDR_EDGE_CLR:  prdata <= {27'h0, edge_pend_q, tli_pend_q};
            `ADDR_HALT_CAP:  prdata <= {18'h0, halt_cap_q};
            default: begin
              prdata  <= 32'h00000000;
              pslverr <= 1'b1;
            end
          endcase
        end
      end
      case (state_q)
        S_RESET: begin
          vec_q      <= `VEC_RESET;
          new_pair_q <= `LVL3;
          win_nmi_q  <= 1'b1;
          cnt_q      <= `FETCH_CYCLES;
          state_q    <= S_FETCH;
        end
        S_RUN: begin
          if (cpu_instr_end && (take_tli || take_trap || best_ok)) begin
            if (take_tli) begin
              vec_q <= `VEC_TLI;
              new_pair_q <= `LVL3;
              win_nmi_q <= 1'b1;
            end else if (take_trap) begin
              vec_q <= `VEC_TRAP;
              new_pair_q <= `LVL3;
              win_nmi_q <= 1'b1;
              trap_pend_q <= 1'b0;
            end else begin
              vec_q <= `VEC_BASE + {11'h0, 4'hD - best_idx, 1'b0};
              new_pair_q <= prio_q[best_idx*2 +: 2];
              win_q <= best_idx;
              win_nmi_q <= 1'b0;
            end
            saved_q[depth_q] <= pair_q;
            depth_q <= depth_q + 2'h1;
            cnt_q <= `STACK_CYCLES;
            state_q <= S_STACK;
          end
        end
        S_STACK: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            cnt_q <= `FETCH_CYCLES;
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            pair_q <= new_pair_q;
            halt_exit_q <= 1'b0;
            state_q <= S_RUN;
          end
        end
        S_HALT: begin
          if (take_tli || take_trap || (best_ok && halt_cap_q[best_idx])) begin
            halt_exit_q <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_WAIT: begin
          if (take_tli || take_trap || any_req)
            state_q <= S_RUN;
        end
        default: state_q <= S_RUN;
      endcase
      cc_out      <= {2'h0, pair_q[1], 1'b0, pair_q[0], 3'h0};
      cpu_stack   <= state_q == S_STACK;
      cpu_fetch   <= state_q == S_FETCH;
      cpu_vector  <= vec_q;
      cpu_halted  <= state_q == S_HALT;
      cpu_waiting <= state_q == S_WAIT;
    end
  end
endmodule
`default_nettype wire

// ===== verification/nic_sva.sv
`timescale 1ns/1ps
`default_nettype none
module nic_sva (
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, active low
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic [7:0]  cc_out,     // Pair bits
  input wire logic        cpu_stack,  // Stacking
  input wire logic        cpu_fetch,  // Fetching
  input wire logic [15:0] cpu_vector  // Vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence stack_s;
    cpu_stack [*5];
  endsequence
  sequence fetch_s;
    (!cpu_stack && cpu_fetch) [*2];
  endsequence
  reset_level_a: assert property ($rose(presetn) |-> cc_out == 8'h28)
    else $error("cc_out not level 3 after reset");
  pair_bits_a: assert property ((cc_out & 8'hD7) == 8'h00)
    else $error("cc_out has bits outside 5 and 3");
  entry_seq_a: assert property ($rose(cpu_stack) |-> stack_s ##1 fetch_s)
    else $error("entry sequence malformed");
  vec_range_a: assert property (cpu_fetch |-> cpu_vector >= 16'hFFE0 && !cpu_vector[0])
    else $error("vector outside top of memory");
  nmi_level_a: assert property ($fell(cpu_fetch) && $past(cpu_vector) inside {16'hFFFC, 16'hFFFA}
    |-> ##[0:2] cc_out == 8'h28)
    else $error("non-maskable entry not at level 3");
  level3_block_a: assert property ($rose(cpu_stack) && $past(cc_out) == 8'h28
    |-> ##5 cpu_fetch && cpu_vector >= 16'hFFFA)
    else $error("maskable taken at level 3");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule
bind nested_interrupt_controller nic_sva nic_sva_i (.pclk, .presetn, .pready, .pslverr, .cc_out,
  .cpu_stack, .cpu_fetch, .cpu_vector);
`default_nettype wire

// ===== verification/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       pclk,          // Clock
  input  wire logic       presetn,       // Reset, active low
  input  wire logic       cpu_stack,     // Stacking
  input  wire logic       cpu_fetch,     // Fetching
  input  wire logic       cpu_halted,    // Clock stopped
  input  wire logic [9:0] flag_set,      // Raise flags
  input  wire logic [9:0] flag_clr,      // Drop flags
  output logic            cpu_instr_end, // Boundary
  output logic [9:0]      periph_flag    // Status flags
);
  logic phase_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q       <= 1'b0;
      cpu_instr_end <= 1'b0;
      periph_flag   <= 10'h000;
    end else begin
      phase_q       <= ~phase_q;
      // Two-cycle instructions, none while entering or stopped
      cpu_instr_end <= phase_q && !cpu_stack && !cpu_fetch && !cpu_halted;
      periph_flag   <= (periph_flag | flag_set) & ~flag_clr;
    end
  end
endmodule
`default_nettype wire

// ===== verification/nested_interrupt_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_controller_bench;
  logic        pclk, presetn, psel, penable, pwrite, tli_pin, err;
  logic        pready, pslverr, cpu_instr_end, cpu_stack, cpu_fetch, cpu_halted, cpu_waiting;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ext_pins, ext_pin_sel, cpu_vector;
  logic [9:0]  periph_flag, flag_set, flag_clr;
  logic [7:0]  cc_out;
  integer      mismatches, check_count, cycles;
  nested_interrupt_controller nested_interrupt_controller_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tli_pin, .ext_pins, .ext_pin_sel, .periph_flag,
    .cpu_instr_end, .cc_out, .cpu_stack, .cpu_fetch, .cpu_vector, .cpu_halted, .cpu_waiting);
  core_model core_model_i (.pclk, .presetn, .cpu_stack, .cpu_fetch, .cpu_halted, .flag_set,
    .flag_clr, .cpu_instr_end, .periph_flag);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic entry(input logic [15:0] vec, input logic [7:0] cc);
    while (cpu_fetch !== 1'b1) @(posedge pclk);
    check(cpu_vector, vec);
    repeat (4) @(posedge pclk);
    check(cc_out, cc);
  endtask
  task automatic t_reset;
    check(cc_out, 8'h28);
    apb(0, 12'h01C, 0);
    check(rd, 32'h21BF);
    apb(0, 12'h008, 0);
    check(rd, 32'h0FFFFFFF);
    apb(0, 12'h020, 0);
    check(err, 1'b1);
    apb(1, 12'h008, 32'h0FFFFFF2);
    apb(0, 12'h008, 0);
    check(rd, 32'h0FFFFFF3);
  endtask
  task automatic t_ext;
    apb(1, 12'h004, 32'h6);
    apb(1, 12'h000, 32'h24);
    check(cc_out, 8'h20);
    ext_pin_sel <= 16'h0024;
    ext_pins    <= 16'h0024;
    repeat (5) @(posedge pclk);
    ext_pins    <= 16'h0000;
    entry(16'hFFF6, 8'h28);
    apb(1, 12'h000, 32'h14);
    entry(16'hFFF8, 8'h00);
    apb(1, 12'h000, 32'h14);
    repeat (4) @(posedge pclk);
    check(cc_out, 8'h20);
    apb(0, 12'h018, 0);
    check(rd, 32'h0);
  endtask
  task automatic t_trap_tli;
    apb(1, 12'h000, 32'h44);
    apb(1, 12'h004, 32'h3);
    ext_pins <= 16'h0004;
    repeat (5) @(posedge pclk);
    ext_pins <= 16'h0000;
    apb(1, 12'h000, 32'h0C);
    entry(16'hFFFC, 8'h28);
    tli_pin <= 1'b1;
    entry(16'hFFFA, 8'h28);
    tli_pin <= 1'b0;
    apb(1, 12'h000, 32'h14);
    apb(1, 12'h000, 32'h14);
    repeat (20) @(posedge pclk);
    apb(0, 12'h018, 0);
    check(rd, 32'h2);
    apb(1, 12'h018, 32'h1E);
    apb(0, 12'h018, 0);
    check(rd, 32'h0);
  endtask
  task automatic t_periph;
    flag_set <= 10'h001;
    apb(1, 12'h004, 32'h10);
    apb(1, 12'h000, 32'h24);
    repeat (40) @(posedge pclk);
    check(cpu_stack, 1'b0);
    flag_set <= 10'h000;
    apb(1, 12'h00C, 32'h10);
    entry(16'hFFF2, 8'h28);
    flag_clr <= 10'h001;
    apb(1, 12'h000, 32'h14);
    repeat (30) @(posedge pclk);
    check(cc_out, 8'h20);
  endtask
  task automatic t_halt;
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h000, 32'h05);
    check(cpu_halted, 1'b1);
    ext_pins <= 16'h0020;
    repeat (5) @(posedge pclk);
    ext_pins <= 16'h0000;
    entry(16'hFFF6, 8'h28);
    check(cpu_halted, 1'b0);
    apb(1, 12'h000, 32'h14);
    apb(1, 12'h000, 32'h06);
    check(cpu_waiting, 1'b1);
    apb(1, 12'h000, 32'h0C);
    entry(16'hFFFC, 8'h28);
    check(cpu_waiting, 1'b0);
    apb(1, 12'h000, 32'h14);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, tli_pin} = 6'h00;
    {paddr, pwdata, ext_pins, ext_pin_sel} = 76'h0;
    {flag_set, flag_clr} = 20'h0;
    {mismatches, check_count, cycles} = 96'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_ext();
    t_trap_tli();
    t_periph();
    t_halt();
    complete_run();
  end
endmodule
`default_nettype wire
